// file: core/bfs_sequencer.sv
// Top of the step-down converter state, mode and switch sequencer.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module bfs_sequencer
  import bfs_pkg::*;
#(
  parameter int unsigned RETRY_DELAY_CYCLES = bfs_pkg::RETRY_DELAY_CYC
) (
  input  wire logic                      clk_sys,
  input  wire logic                      reset_n,
  // Comparator and pin inputs from the analog stage, asynchronous.
  input  wire logic [bfs_pkg::PIN_COUNT-1:0] pinIn,
  // Register port.
  input  wire logic [7:0]                regAddr,
  input  wire logic [31:0]               regWrData,
  input  wire logic                      regWrEn,
  input  wire logic                      regRdEn,
  output logic      [31:0]               regRdData,
  // Power stage controls.
  output logic                           gateHs,
  output logic                           gateLs,
  output logic                           switchesHiZ,
  output logic                           ldoEnable,
  output logic                           softStartRun,
  output logic                           useInternalRamp,
  output logic                           forcedPwmMode
);
  import bfs_pkg::*;

  // Whole sequencer state in one record.
  typedef struct packed {
    bfs_state_e  state;      // Operating state.
    bfs_phase_e  phase;      // Switch phase within a cycle.
    logic [7:0]  perCnt;     // Oscillator period counter.
    logic        foldSkip;   // Alternating skip used for frequency foldback.
    logic [20:0] retryCnt;   // Hiccup retry wait counter.
    logic [7:0]  syncWatch;  // Cycles since the last sync edge.
    logic        syncPrev;   // Previous filtered sync level.
    logic        afterHic;   // A hiccup has happened since the last standby or shutdown.
    logic        ctrlTrack;  // Software asks for tracking at first start.
    logic [7:0]  period;     // Switching period in clock cycles.
    logic [31:0] rdData;     // Read data, valid one cycle after a read.
  } bfs_seq_s;
  bfs_seq_s r_q, r_d;

  logic [PIN_COUNT-1:0] pinS;       // Filtered pins.
  logic                 syncEdge;   // Rising edge on the sync pin.
  logic                 syncActive; // External clock present.
  logic                 forced_pwm_mode;       // Forced PWM selected.
  logic                 fold;       // Frequency foldback wanted.
  logic                 oscTick;    // Internal oscillator cycle start.
  logic                 tick;       // Cycle start actually used.
  logic                 running;    // Switching allowed.
  logic                 hot;        // Over-temperature flag.

  bfs_hiccup_if hIf ();

  // Pins cross into this clock through the filtered synchroniser.
  bfs_pin_sync #(
    .WIDTH   (PIN_COUNT)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .pinRaw   (pinIn),
    .pinClean (pinS)
  );

  // Under-voltage cycle counter.
  bfs_hiccup_counter u_hic (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .hIf     (hIf)
  );

  // Sync detection: an edge seen within the timeout means an external clock.
  assign syncEdge   = pinS[PIN_SYNC] && !r_q.syncPrev;
  assign syncActive = (r_q.syncWatch != SYNC_TIMEOUT);
  // Mode pin high or a live sync clock select forced PWM.
  assign forced_pwm_mode       = pinS[PIN_MODE] || syncActive;
  // Foldback on a minimum time limit, or on the peak floor in automatic mode only.
  assign fold       = pinS[PIN_MIN_TIME] || (!forced_pwm_mode && pinS[PIN_PEAK_MIN]);
  assign oscTick    = (r_q.perCnt == 8'h00);
  // Cycle start from the sync clock or the period setting; foldback drops alternate starts.
  assign tick       = (syncActive ? syncEdge : oscTick) && !(fold && r_q.foldSkip);
  assign running    = (r_q.state == ST_SOFTSTART) || (r_q.state == ST_ACTIVE);
  assign hot        = pinS[PIN_TEMP_HOT];

  // Counter hookup: detection is blocked outside steady active operation.
  assign hIf.tick   = tick;
  assign hIf.outLow = pinS[PIN_OUT_LOW];
  assign hIf.enable = (r_q.state == ST_ACTIVE);

  // Next-state logic for the operating state, switch phase and registers.
  always_comb begin
    r_d = r_q;
    r_d.rdData   = 32'h0000_0000;
    r_d.syncPrev = pinS[PIN_SYNC];

    // Sync watchdog saturates once the external clock stops.
    if (syncEdge) begin
      r_d.syncWatch = 8'h00;
    end else if (r_q.syncWatch != SYNC_TIMEOUT) begin
      r_d.syncWatch = r_q.syncWatch + 8'h01;
    end

    // Internal oscillator counts down the programmed period.
    if (oscTick) begin
      r_d.perCnt = r_q.period - 8'h01;
    end else begin
      r_d.perCnt = r_q.perCnt - 8'h01;
    end
    // The skip flag toggles on every potential start in foldback and clears otherwise, so half the starts survive foldback.
    if (syncActive ? syncEdge : oscTick) begin
      r_d.foldSkip = fold ? !r_q.foldSkip : 1'b0;
    end

    // Operating state; thermal shutdown is checked first and outranks all.
    if (hot || (r_q.state == ST_THERMAL && !pinS[PIN_TEMP_COOL])) begin
      r_d.state = ST_THERMAL;
    end else if (!pinS[PIN_EN_SUPPLY]) begin
      r_d.state    = ST_SHUTDOWN;
      r_d.afterHic = 1'b0;
    end else if (!pinS[PIN_VCC_OK] || !pinS[PIN_EN_OUTPUT]) begin
      // Lockout or enable below the output threshold parks the stage.
      r_d.state    = ST_STANDBY;
      r_d.afterHic = 1'b0;
    end else begin
      case (r_q.state)
        // Leaving thermal, shutdown or standby always starts soft.
        ST_THERMAL, ST_SHUTDOWN, ST_STANDBY: begin
          r_d.state = ST_SOFTSTART;
        end
        // Soft-start runs until the ramp reports completion.
        ST_SOFTSTART: begin
          if (pinS[PIN_SS_DONE]) begin
            r_d.state = ST_ACTIVE;
          end
        end
        // Only the counter trigger leaves active; overcurrent alone keeps switching.
        ST_ACTIVE: begin
          if (hIf.trigger) begin
            r_d.state    = ST_HICCUP;
            r_d.afterHic = 1'b1;
            r_d.retryCnt = '0;
          end
        end
        // Wait the retry delay, then try again; a lasting fault repeats this.
        ST_HICCUP: begin
          if (r_q.retryCnt == 21'(RETRY_DELAY_CYCLES - 1)) begin
            r_d.state = ST_SOFTSTART;
          end else begin
            r_d.retryCnt = r_q.retryCnt + 21'h000001;
          end
        end
        default: begin
          r_d.state = ST_SHUTDOWN;
        end
      endcase
    end

    // Switch phase; without permission to switch both gates idle.
    if (!running || r_d.state != r_q.state && !(r_d.state == ST_ACTIVE)) begin
      r_d.phase = PH_OFF;
    end else begin
      case (r_q.phase)
        // High side ends at the peak limit or the loop's trip point.
        PH_HIGH: begin
          if (pinS[PIN_HS_PEAK] || pinS[PIN_PWM_TRIP]) begin
            r_d.phase = PH_LOW;
          end
        end
        // Low side: cycle end, diode emulation and negative limit.
        PH_LOW: begin
          if (tick) begin
            // Above the valley limit the cycle is stretched.
            r_d.phase = pinS[PIN_LS_VALLEY] ? PH_LOW : PH_HIGH;
          end else if (!forced_pwm_mode && pinS[PIN_LS_ZERO] && !pinS[PIN_LS_VALLEY]) begin
            r_d.phase = PH_OFF;
          end else if (forced_pwm_mode && pinS[PIN_NEG_LIM]) begin
            r_d.phase = PH_NEGHI;
          end
        end
        // High side carries the negative current until it reaches zero.
        PH_NEGHI: begin
          if (pinS[PIN_HS_ZERO]) begin
            r_d.phase = PH_OFF;
          end
        end
        // Idle until the next cycle start.
        PH_OFF: begin
          if (tick) begin
            r_d.phase = PH_HIGH;
          end
        end
        default: begin
          r_d.phase = PH_OFF;
        end
      endcase
    end

    // Register writes; the period never goes below two clocks.
    if (regWrEn) begin
      if (regAddr == ADDR_CTRL) begin
        r_d.ctrlTrack = regWrData[0];
      end else if (regAddr == ADDR_PERIOD) begin
        r_d.period = (regWrData[7:0] < 8'h02) ? 8'h02 : regWrData[7:0];
      end
    end
    // Register reads; unmapped addresses answer zero.
    if (regRdEn) begin
      case (regAddr)
        ADDR_CTRL:   r_d.rdData = {31'h0000_0000, r_q.ctrlTrack};
        ADDR_PERIOD: r_d.rdData = {24'h00_0000, r_q.period};
        ADDR_STATUS: r_d.rdData = {12'h000, r_q.phase, hIf.count, r_q.afterHic,
                                   forced_pwm_mode, r_q.state};
        default:     r_d.rdData = 32'h0000_0000;
      endcase
    end
  end

  // State register; all fields take constants on reset.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      r_q           <= '0;
      r_q.state     <= ST_SHUTDOWN;
      r_q.phase     <= PH_OFF;
      r_q.syncWatch <= SYNC_TIMEOUT;
      r_q.ctrlTrack <= CTRL_RESET;
      r_q.period    <= PERIOD_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs, all from flip-flops.
  assign gateHs          = (r_q.phase == PH_HIGH) || (r_q.phase == PH_NEGHI);
  assign gateLs          = (r_q.phase == PH_LOW);
  assign switchesHiZ     = !running;
  assign ldoEnable       = (r_q.state != ST_SHUTDOWN);
  assign softStartRun    = (r_q.state == ST_SOFTSTART);
  // Tracking is honoured only for a first start, never after a hiccup.
  assign useInternalRamp = r_q.afterHic || !r_q.ctrlTrack;
  assign forcedPwmMode   = forced_pwm_mode;
  assign regRdData       = r_q.rdData;

  // Checks that tie the outputs to their causes.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_hs_peak;
    gateHs && (r_q.phase == PH_HIGH) && pinS[PIN_HS_PEAK] |=> !gateHs;
  endproperty
  a_hs_peak: assert property (p_hs_peak) else $error("high side on after peak limit");

  property p_ls_extend;
    running && gateLs && tick && pinS[PIN_LS_VALLEY] && !hot
      && r_d.state == r_q.state |=> gateLs && !gateHs;
  endproperty
  a_ls_extend: assert property (p_ls_extend) else $error("low side released early");

  property p_hiccup_cause;
    $rose(r_q.state == ST_HICCUP) |-> $past(hIf.trigger) && $past(hIf.count) == HICCUP_LAST;
  endproperty
  a_hiccup_cause: assert property (p_hiccup_cause) else $error("hiccup without count");

  property p_no_hiccup_soft;
    r_q.state == ST_SOFTSTART |=> r_q.state != ST_HICCUP;
  endproperty
  a_no_hiccup_soft: assert property (p_no_hiccup_soft) else $error("hiccup in soft-start");

  property p_off_in_fault;
    (r_q.state == ST_HICCUP || r_q.state == ST_THERMAL) |-> !gateHs && !gateLs;
  endproperty
  a_off_in_fault: assert property (p_off_in_fault) else $error("switch on during fault");

  property p_thermal_hold;
    r_q.state == ST_THERMAL && !pinS[PIN_TEMP_COOL] |=> r_q.state == ST_THERMAL;
  endproperty
  a_thermal_hold: assert property (p_thermal_hold) else $error("left thermal while hot");

  property p_shutdown;
    !pinS[PIN_EN_SUPPLY] && !hot && r_q.state != ST_THERMAL |=> !ldoEnable ##1 !ldoEnable
      || pinS[PIN_EN_SUPPLY] || hot;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("regulator on in shutdown");

  property p_active_cause;
    $rose(r_q.state == ST_SOFTSTART) |-> $past(pinS[PIN_EN_OUTPUT]) && $past(pinS[PIN_VCC_OK]);
  endproperty
  a_active_cause: assert property (p_active_cause) else $error("start without enable");

  property p_internal_ramp;
    $rose(r_q.state == ST_SOFTSTART) && $past(r_q.state == ST_HICCUP) |-> useInternalRamp;
  endproperty
  a_internal_ramp: assert property (p_internal_ramp) else $error("tracking after hiccup");

  property p_neg_limit;
    gateLs && pinS[PIN_NEG_LIM] && forced_pwm_mode && !tick && running && !hot
      && r_d.state == r_q.state |=> gateHs && !gateLs;
  endproperty
  a_neg_limit: assert property (p_neg_limit) else $error("negative limit ignored");

  // Ties between filtered pins, state and gates; each effect lands one edge after its cause, except the mode pin check, which holds in the same cycle.
  property p_standby_hiz;
    !pinS[PIN_EN_OUTPUT] |=> switchesHiZ && !gateHs && !gateLs;
  endproperty
  a_standby_hiz: assert property (p_standby_hiz) else $error("gate in standby");

  property p_vcc_lockout;
    !pinS[PIN_VCC_OK] |=> !running;
  endproperty
  a_vcc_lockout: assert property (p_vcc_lockout) else $error("on in lockout");

  property p_ccm_start;
    running && r_q.phase == PH_OFF && tick && r_d.state == r_q.state |=> gateHs;
  endproperty
  a_ccm_start: assert property (p_ccm_start) else $error("no start pulse");

  property p_forced_pwm_mode_ccm;
    forced_pwm_mode && gateLs && !tick && !pinS[PIN_NEG_LIM] && running && r_d.state == r_q.state
      |=> gateLs;
  endproperty
  a_forced_pwm_mode_ccm: assert property (p_forced_pwm_mode_ccm) else $error("left low side early");

  property p_dcm_off;
    !forced_pwm_mode && gateLs && !tick && pinS[PIN_LS_ZERO] && !pinS[PIN_LS_VALLEY] && running
      && r_d.state == r_q.state |=> !gateLs && !gateHs;
  endproperty
  a_dcm_off: assert property (p_dcm_off) else $error("no diode emulation");

  property p_retry_wait;
    r_q.state == ST_HICCUP && r_q.retryCnt != 21'(RETRY_DELAY_CYCLES - 1)
      |=> r_q.state != ST_SOFTSTART;
  endproperty
  a_retry_wait: assert property (p_retry_wait) else $error("early retry");

  property p_mode_pin;
    pinS[PIN_MODE] |-> forcedPwmMode;
  endproperty
  a_mode_pin: assert property (p_mode_pin) else $error("mode pin ignored");

  property p_hot_entry;
    hot |=> r_q.state == ST_THERMAL;
  endproperty
  a_hot_entry: assert property (p_hot_entry) else $error("thermal not entered");

  // Main scenarios reached.
  c_hiccup:  cover property ($rose(r_q.state == ST_HICCUP));
  c_retry:   cover property (r_q.state == ST_HICCUP ##1 r_q.state == ST_SOFTSTART);
  c_thermal: cover property ($rose(r_q.state == ST_THERMAL));
  c_neghi:   cover property (r_q.phase == PH_NEGHI);
  c_dcm:     cover property (!forced_pwm_mode && gateLs ##1 running && r_q.phase == PH_OFF);
endmodule // bfs_sequencer

// file: core/bfs_pkg.sv
// Package with constants, states and pin indices of the converter sequencer.
// What this block does
// - High side off on peak limit
// - Low side held until below valley limit
// - Hiccup after 128 cycles below 40%
// - Above 40% keep switching with limiting
// - No hiccup detection during soft-start
// - Hiccup waits retry delay then soft-starts
// - Repeat retry while fault persists
// - Restart after hiccup uses internal ramp
// - Forced PWM negative limit swaps switches
// - Thermal stop above 160, resume below 135
// - Low enable means shutdown, regulator off
// - Standby keeps switches tri-stated
// - Internal supply lockout turns output off
// - Active only with enable and supply
// - Continuous: high on at start, low off at end
// - Continuous in forced PWM at every load
// - Frequency from period setting or sync
// - Fold frequency on minimum time limit
// - Peak floor only in automatic mode
// - Automatic light load: low off at zero
// - Pulse frequency mode below peak floor
// - Mode pin low automatic, high forced PWM
package bfs_pkg;
  // Register byte addresses and reset values.
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_PERIOD   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  PERIOD_RESET  = 8'h19;
  localparam logic        CTRL_RESET    = 1'h0;
  // Hiccup counting and sync supervision.
  localparam logic [7:0]  HICCUP_LAST   = 8'h7f;
  localparam logic [7:0]  SYNC_TIMEOUT  = 8'hff;
  // Retry delay in its own unit and as clock cycles.
  localparam int          CLK_HZ            = 25000000;
  localparam int          RETRY_DELAY_MS    = 46;
  localparam int          RETRY_DELAY_CYC   = RETRY_DELAY_MS * (CLK_HZ / 1000);
  // Positions of the synchronised pin inputs.
  localparam int PIN_EN_SUPPLY = 0;
  localparam int PIN_EN_OUTPUT = 1;
  localparam int PIN_VCC_OK    = 2;
  localparam int PIN_TEMP_HOT  = 3;
  localparam int PIN_TEMP_COOL = 4;
  localparam int PIN_HS_PEAK   = 5;
  localparam int PIN_LS_VALLEY = 6;
  localparam int PIN_NEG_LIM   = 7;
  localparam int PIN_HS_ZERO   = 8;
  localparam int PIN_LS_ZERO   = 9;
  localparam int PIN_OUT_LOW   = 10;
  localparam int PIN_MIN_TIME  = 11;
  localparam int PIN_PEAK_MIN  = 12;
  localparam int PIN_PWM_TRIP  = 13;
  localparam int PIN_SS_DONE   = 14;
  localparam int PIN_MODE      = 15;
  localparam int PIN_SYNC      = 16;
  localparam int PIN_COUNT     = 17;
  // Operating state, one-hot.
  typedef enum logic [5:0] {
    ST_SHUTDOWN = 6'h01, ST_STANDBY = 6'h02, ST_SOFTSTART = 6'h04,
    ST_ACTIVE   = 6'h08, ST_HICCUP  = 6'h10, ST_THERMAL   = 6'h20
  } bfs_state_e;
  // Switching phase inside one cycle, one-hot.
  typedef enum logic [3:0] {
    PH_OFF = 4'h1, PH_HIGH = 4'h2, PH_LOW = 4'h4, PH_NEGHI = 4'h8
  } bfs_phase_e;
endpackage

// file: core/bfs_hiccup_if.sv
// Interface between the sequencer and its under-voltage cycle counter.
`timescale 1ns/1ps
interface bfs_hiccup_if;
  logic       tick;      // One pulse per switching cycle.
  logic       outLow;    // Output below 40 percent of regulation.
  logic       enable;    // Counting allowed.
  logic       trigger;   // Pulse when the 128th cycle is counted.
  logic [7:0] count;     // Cycles counted so far.
  modport seq (output tick, output outLow, output enable, input trigger, input count);
  modport cnt (input tick, input outLow, input enable, output trigger, output count);
endinterface // bfs_hiccup_if

// file: core/bfs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module bfs_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pinRaw,
  output logic      [WIDTH-1:0] pinClean
);
  // All state in one struct; the filter only moves when stages two and three agree.
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] clean;
  } bfs_sync_s;
  bfs_sync_s r_q, r_d;

  // Next-state logic; stage one feeds stage two only.
  always_comb begin
    r_d = r_q;
    r_d.s1 = pinRaw;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) begin
        r_d.clean[i] = r_q.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign pinClean = r_q.clean;
endmodule // bfs_pin_sync

// file: core/bfs_hiccup_counter.sv
// Counter of consecutive switching cycles with the output below 40 percent.
`timescale 1ns/1ps
module bfs_hiccup_counter (
  input wire logic clk_sys,
  input wire logic reset_n,
  bfs_hiccup_if.cnt hIf
);
  import bfs_pkg::*;
  typedef struct packed {
    logic [7:0] count;
  } bfs_cnt_s;
  bfs_cnt_s r_q, r_d;
  logic hit;

  // The trigger fires on the cycle that would make the count 128.
  assign hit = hIf.enable && hIf.tick && hIf.outLow && (r_q.count == HICCUP_LAST);

  // Count only while enabled; any recovery of the output restarts the count.
  always_comb begin
    r_d = r_q;
    if (!hIf.enable || !hIf.outLow) begin
      r_d.count = '0;
    end else if (hIf.tick) begin
      r_d.count = hit ? 8'h00 : r_q.count + 8'h01;
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign hIf.trigger = hit;
  assign hIf.count   = r_q.count;

  // A recovery always restarts the count from zero.
  property p_count_clear;
    @(posedge clk_sys) disable iff (!reset_n) !hIf.outLow |=> hIf.count == 8'h00;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("count not cleared");
endmodule // bfs_hiccup_counter

// file: bench/bfs_stage_model.sv
// Behavioural model of the power stage current comparators.
`timescale 1ns/1ps
module bfs_stage_model #(
  parameter int PEAK_LIM = 12,  // Peak limit in current steps.
  parameter int VALLEY   = 4,   // Valley limit in current steps.
  parameter int TRIP_LVL = 6    // Loop trip level under normal load.
) (
  input  wire logic       clk_sys,
  input  wire logic       gateHs,
  input  wire logic       gateLs,
  input  wire logic       overload,
  output logic      [5:0] cmpOut
);
  int cur;  // Inductor current in signed steps.
  // The current climbs with the high side on and falls with the low side on.
  always @(posedge clk_sys) begin
    if (gateHs) begin
      cur <= cur + (overload ? 3 : 1);
    end else if (gateLs) begin
      cur <= cur - 1;
    end else begin
      cur <= 0;  // Open switches let the current die out.
    end
  end
  // An overload hides the loop trip, so only the peak limit can end a pulse.
  assign cmpOut = {(cur >= TRIP_LVL) && !overload, cur <= 0, cur >= 0,
                   cur <= -3, cur > VALLEY, cur >= PEAK_LIM};
endmodule // bfs_stage_model

// file: bench/tb_top.sv
// Self-checking bench of the converter sequencer against a power stage model.
`timescale 1ns/1ps
module tb_top;
  import bfs_pkg::*;
  localparam int unsigned RETRY = 20;  // Short retry delay keeps the run brief.
  localparam int          TICK  = 8;   // Switching period used in the run.
  logic                 clk_sys, reset_n, overload;
  logic [PIN_COUNT-1:0] pinTb, pinIn;
  logic [5:0]           cmp;
  logic [7:0]           regAddr, v;
  logic [31:0]          regWrData, regRdData, rd;
  logic                 regWrEn, regRdEn, gateHs, gateLs, switchesHiZ, ldoEnable;
  logic                 softStartRun, useInternalRamp, forcedPwmMode, hizPrev, lsPrev;
  int                   error_cnt, checks, hsCnt;
  // Current comparators come from the model, every other pin from the bench.
  assign pinIn = {pinTb[16:14], cmp[5], pinTb[12:10], cmp[4:0], pinTb[4:0]};
  bfs_sequencer #(.RETRY_DELAY_CYCLES(RETRY)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .pinIn(pinIn), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .gateHs(gateHs), .gateLs(gateLs),
    .switchesHiZ(switchesHiZ), .ldoEnable(ldoEnable), .softStartRun(softStartRun),
    .useInternalRamp(useInternalRamp), .forcedPwmMode(forcedPwmMode));
  bfs_stage_model stage (.clk_sys(clk_sys), .gateHs(gateHs), .gateLs(gateLs),
    .overload(overload), .cmpOut(cmp));
  // Free-running 25 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Reports one mismatch.
  task automatic fail(input string what);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, what);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail($sformatf("%s got %h exp %h", what, got, exp));
    end
  endtask
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  // The read data stand only in the cycle after the strobe, so sample there.
  task automatic regRd(input logic [7:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1 rd = regRdData;
  endtask
  task automatic state(input logic [5:0] e);
    regRd(ADDR_STATUS);
    chk({26'h0, rd[5:0]}, {26'h0, e}, "state");
  endtask
  // Waits long enough for the filter and for at least one switching tick.
  task automatic pin(input int i, input logic val);
    @(posedge clk_sys);
    pinTb[i] <= val;
    repeat (12) @(posedge clk_sys);
  endtask
  // Counts cycles until the switches reach a level and checks the span.
  task automatic waitHiz(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (switchesHiZ !== lvl && n < hi) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(n >= lo && n < hi, 1, $sformatf("span %0d", n));
  endtask
  // Short period values are raised to the smallest legal period.
  function automatic logic [31:0] perRef(input logic [7:0] p);
    return (p < 8'h02) ? 32'h2 : {24'h0, p};
  endfunction
  // Gate monitors: the peak limit must end a pulse within the filter delay, the low
  // side may not drop above the valley, and tri-stated switches carry no gate drive.
  always @(posedge clk_sys) begin
    hizPrev <= switchesHiZ;
    lsPrev <= gateLs;
    hsCnt <= (gateHs && cmp[0]) ? hsCnt + 1 : 0;
    if (hsCnt == 3) checks++;
    if (hsCnt == 7) fail("high side held over peak");
    if (lsPrev && !gateLs && cmp[1] && !switchesHiZ) fail("low side off early");
    if (hizPrev && switchesHiZ && (gateHs || gateLs)) fail("gate while off");
  end
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog sized well above the expected run of some seven thousand cycles.
  initial begin
    #2400000;
    fail("watchdog");
    tally_and_finish();
  end
  initial begin
    reset_n = 1'b0;
    pinTb = '0;
    overload = 1'b0;
    regAddr = 8'h00;
    regWrData = '0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    void'($urandom(32'hfb2d));
    repeat (11) @(posedge clk_sys);
    #1 chk({gateHs, gateLs, switchesHiZ, ldoEnable}, 4'b0010, "reset outputs");
    @(posedge clk_sys);
    reset_n <= 1'b1;
    regRd(ADDR_PERIOD);
    chk(rd, 32'h19, "period reset");
    regRd(ADDR_CTRL);
    chk(rd, 32'h0, "ctrl reset");
    regRd(8'h0c);
    chk(rd, 32'h0, "unmapped");
    // Random periods, the first two being the clamped corner values.
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? i[7:0] : 8'($urandom % 40);
      regWr(ADDR_PERIOD, {24'h0, v});
      regRd(ADDR_PERIOD);
      chk(rd, perRef(v), "period");
    end
    regWr(ADDR_PERIOD, TICK);
    regWr(ADDR_CTRL, 32'h1);
    state(ST_SHUTDOWN);
    chk(ldoEnable, 1'b0, "ldo in shutdown");
    pin(PIN_EN_SUPPLY, 1'b1);
    pin(PIN_VCC_OK, 1'b1);
    state(ST_STANDBY);
    chk({ldoEnable, switchesHiZ}, 2'b11, "standby");
    pin(PIN_EN_OUTPUT, 1'b1);
    state(ST_SOFTSTART);
    chk({softStartRun, useInternalRamp}, 2'b10, "tracked first start");
    // A low output during the ramp must not count toward hiccup.
    pin(PIN_OUT_LOW, 1'b1);
    repeat (200 * TICK) @(posedge clk_sys);
    state(ST_SOFTSTART);
    pin(PIN_OUT_LOW, 1'b0);
    pin(PIN_SS_DONE, 1'b1);
    state(ST_ACTIVE);
    waitHiz(1'b0, 0, 4);
    repeat (4) begin
      v = 8'($urandom % 2);
      pin(PIN_MODE, v[0]);
      chk(forcedPwmMode, v[0], "mode");
    end
    // A live sync clock forces PWM over a low mode pin; once it stops the pin rules again.
    pin(PIN_MODE, 1'b0);
    repeat (16) begin
      pinTb[PIN_SYNC] <= ~pinTb[PIN_SYNC];
      repeat (TICK / 2) @(posedge clk_sys);
    end
    chk(forcedPwmMode, 1'b1, "sync mode");
    repeat (300) @(posedge clk_sys);
    chk(forcedPwmMode, 1'b0, "sync lost");
    // An overload with the output above the hiccup level keeps switching.
    overload <= 1'b1;
    repeat (60 * TICK) @(posedge clk_sys);
    state(ST_ACTIVE);
    overload <= 1'b0;
    // A short recovery restarts the under-voltage count from zero.
    pin(PIN_OUT_LOW, 1'b1);
    repeat (100 * TICK) @(posedge clk_sys);
    pin(PIN_OUT_LOW, 1'b0);
    pin(PIN_OUT_LOW, 1'b1);
    waitHiz(1'b1, 120 * TICK, 136 * TICK);
    waitHiz(1'b0, RETRY - 2, RETRY + 6);
    chk(useInternalRamp, 1'b1, "internal ramp");
    waitHiz(1'b1, 120 * TICK, 140 * TICK);
    pin(PIN_OUT_LOW, 1'b0);
    repeat (200 * TICK) @(posedge clk_sys);
    state(ST_ACTIVE);
    pin(PIN_VCC_OK, 1'b0);
    state(ST_STANDBY);
    pin(PIN_VCC_OK, 1'b1);
    pin(PIN_TEMP_HOT, 1'b1);
    state(ST_THERMAL);
    pin(PIN_TEMP_HOT, 1'b0);
    state(ST_THERMAL);
    pin(PIN_TEMP_COOL, 1'b1);
    state(ST_ACTIVE);
    tally_and_finish();
  end
endmodule // tb_top
